// ===== rtc_cal_pkg.sv
`default_nettype none
package rtc_cal_pkg;
    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [9:0] IDX_HOUR = 10'h322;
    localparam logic [9:0] IDX_WEEKDAY = 10'h323;
    localparam logic [9:0] IDX_MDAY = 10'h324;
    localparam logic [9:0] IDX_MONTH = 10'h325;
    localparam logic [9:0] IDX_PAGE = 10'h327;
    localparam int ADDR_W = 12;

    // ------------------------------------------------------------
    // field positions and widths
    // ------------------------------------------------------------
    localparam int HOUR_W = 6;
    localparam int WEEKDAY_W = 3;
    localparam int MDAY_W = 6;
    localparam int MONTH_W = 5;
    localparam int HOUR_PM_BIT = 5;
    localparam int FMT_BIT = 0;
    localparam int PAGE_BIT = 0;

    // ------------------------------------------------------------
    // counter limits, bcd coded
    // ------------------------------------------------------------
    localparam logic [7:0] HOUR24_LAST = 8'h23;
    localparam logic [7:0] HOUR12_LAST = 8'h11;
    localparam logic [2:0] WEEKDAY_LAST = 3'h6;
    localparam logic [7:0] MONTH_LAST = 8'h12;
    localparam logic [7:0] MONTH_FEB = 8'h02;
    localparam logic [7:0] MONTH_APR = 8'h04;
    localparam logic [7:0] MONTH_JUN = 8'h06;
    localparam logic [7:0] MONTH_SEP = 8'h09;
    localparam logic [7:0] MONTH_NOV = 8'h11;
    localparam logic [7:0] DAYS_31 = 8'h31;
    localparam logic [7:0] DAYS_30 = 8'h30;
    localparam logic [7:0] DAYS_29 = 8'h29;
    localparam logic [7:0] DAYS_28 = 8'h28;

    // ------------------------------------------------------------
    // reset values (hardware leaves them undefined; fixed here)
    // ------------------------------------------------------------
    localparam logic [5:0] HOUR_RST = 6'h00;
    localparam logic [2:0] WEEKDAY_RST = 3'h0;
    localparam logic [5:0] MDAY_RST = 6'h01;
    localparam logic [4:0] MONTH_RST = 5'h01;
    localparam logic FMT_RST = 1'b1;
    localparam logic PAGE_RST = 1'b0;

    // ------------------------------------------------------------
    // axi response codes
    // ------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// ===== calendar_next.sv
`timescale 1ns/1ns
`default_nettype none
module calendar_next
(
    input wire logic hour_carry, // one-cycle tick from minute counter
    input wire logic fmt24, // 1: 24-hour counting
    input wire logic leap_year, // current year is a leap year
    input wire logic [5:0] hour, // current hour
    input wire logic [2:0] weekday, // current weekday
    input wire logic [5:0] mday, // current day of month
    input wire logic [4:0] month, // current month
    output logic [5:0] hour_nxt, // hour after this cycle
    output logic [2:0] weekday_nxt, // weekday after this cycle
    output logic [5:0] mday_nxt, // day of month after this cycle
    output logic [4:0] month_nxt, // month after this cycle
    output logic year_carry // pulse on december rollover
);
    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        if (v[3:0] == 4'h9)
        begin
            bcd_inc = {v[7:4] + 4'h1, 4'h0};
        end
        else
        begin
            bcd_inc = {v[7:4], v[3:0] + 4'h1};
        end
    endfunction

    logic [7:0] h8;
    logic [7:0] h12;
    logic [7:0] d8;
    logic [7:0] m8;
    logic [7:0] last_day;
    logic day_carry;
    logic month_carry;
    logic [7:0] tmp;
    logic [7:0] d_inc;
    logic [7:0] m_inc;

    assign h8 = {2'h0, hour};
    assign h12 = {3'h0, hour[4:0]};
    assign d8 = {2'h0, mday};
    assign m8 = {3'h0, month};
    assign d_inc = bcd_inc(d8);
    assign m_inc = bcd_inc(m8);

    always_comb
    begin
        if (m8 == rtc_cal_pkg::MONTH_FEB)
        begin
            last_day = leap_year ? rtc_cal_pkg::DAYS_29 : rtc_cal_pkg::DAYS_28;
        end
        else if (m8 == rtc_cal_pkg::MONTH_APR || m8 == rtc_cal_pkg::MONTH_JUN
                 || m8 == rtc_cal_pkg::MONTH_SEP
                 || m8 == rtc_cal_pkg::MONTH_NOV)
        begin
            last_day = rtc_cal_pkg::DAYS_30;
        end
        else
        begin
            last_day = rtc_cal_pkg::DAYS_31;
        end
    end

    // ------------------------------------------------------------
    // hour counter
    // ------------------------------------------------------------
    always_comb
    begin
        tmp = 8'h00;
        hour_nxt = hour;
        day_carry = 1'b0;
        if (hour_carry && fmt24)
        begin
            if (h8 == rtc_cal_pkg::HOUR24_LAST)
            begin
                hour_nxt = 6'h00;
                day_carry = 1'b1;
            end
            else
            begin
                tmp = bcd_inc(h8);
                hour_nxt = tmp[5:0];
            end
        end
        else if (hour_carry)
        begin
            if (h12 == rtc_cal_pkg::HOUR12_LAST)
            begin
                hour_nxt = {~hour[rtc_cal_pkg::HOUR_PM_BIT], 5'h00};
                day_carry = hour[rtc_cal_pkg::HOUR_PM_BIT];
            end
            else
            begin
                tmp = bcd_inc(h12);
                hour_nxt = {hour[rtc_cal_pkg::HOUR_PM_BIT], tmp[4:0]};
            end
        end
    end

    // ------------------------------------------------------------
    // date counters
    // ------------------------------------------------------------
    always_comb
    begin
        weekday_nxt = weekday;
        mday_nxt = mday;
        month_nxt = month;
        month_carry = 1'b0;
        year_carry = 1'b0;
        if (day_carry)
        begin
            if (weekday == rtc_cal_pkg::WEEKDAY_LAST)
            begin
                weekday_nxt = 3'h0;
            end
            else
            begin
                weekday_nxt = weekday + 3'h1;
            end
            if (d8 >= last_day)
            begin
                mday_nxt = 6'h01;
                month_carry = 1'b1;
            end
            else
            begin
                mday_nxt = d_inc[5:0];
            end
        end
        if (month_carry)
        begin
            if (m8 == rtc_cal_pkg::MONTH_LAST)
            begin
                month_nxt = 5'h01;
                year_carry = 1'b1;
            end
            else
            begin
                month_nxt = m_inc[4:0];
            end
        end
    end
endmodule
`default_nettype wire

// ===== rtc_calendar_time_registers.sv
// How it works
// - hour register, six bits, upper bits zero
// - 24-hour mode: bcd twenties, tens, units
// - 12-hour mode: bit5 pm flag, 0..11
// - weekday code 0 sunday to 6 saturday
// - day of month bcd 1 to 31
// - page zero month bcd 1 to 12
// - page one month address shows format bit
// - page bit selects view; no read-modify-write
`timescale 1ns/1ns
`default_nettype none
module rtc_calendar_time_registers
(
    input wire logic ref_clk, // 25 mhz clock
    input wire logic rst_n, // async reset, active low
    input wire logic hour_carry, // one-cycle tick from minute counter
    input wire logic leap_year, // current year is a leap year
    output logic year_carry, // pulse on december rollover
    input wire logic [11:0] s_axi_awaddr, // write address
    input wire logic [2:0] s_axi_awprot, // write protection, unused
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write byte strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [11:0] s_axi_araddr, // read address
    input wire logic [2:0] s_axi_arprot, // read protection, unused
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready // read data ready
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [5:0] hour_count_r;
    logic [2:0] weekday_count_r;
    logic [5:0] month_day_count_r;
    logic [4:0] month_count_r;
    logic clock_format_select_r;
    logic bank_one_view_r;
    logic [5:0] hour_nxt;
    logic [2:0] weekday_nxt;
    logic [5:0] mday_nxt;
    logic [4:0] month_nxt;
    logic aw_held_r;
    logic w_held_r;
    logic [9:0] aw_idx_r;
    logic [7:0] wbyte_r;
    logic wlane_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic wr_fire;
    logic wr_en;
    logic [9:0] ar_idx;
    logic [7:0] rd_byte;

    function automatic logic reg_hit(input logic [9:0] idx);
        reg_hit = (idx >= rtc_cal_pkg::IDX_HOUR
                   && idx <= rtc_cal_pkg::IDX_MONTH)
                  || idx == rtc_cal_pkg::IDX_PAGE;
    endfunction

    calendar_next u_next
    (
        .hour_carry(hour_carry),
        .fmt24(clock_format_select_r),
        .leap_year(leap_year),
        .hour(hour_count_r),
        .weekday(weekday_count_r),
        .mday(month_day_count_r),
        .month(month_count_r),
        .hour_nxt(hour_nxt),
        .weekday_nxt(weekday_nxt),
        .mday_nxt(mday_nxt),
        .month_nxt(month_nxt),
        .year_carry(year_carry)
    );

    // ------------------------------------------------------------
    // write channel
    // ------------------------------------------------------------
    assign s_axi_awready = !aw_held_r && !bvalid_r;
    assign s_axi_wready = !w_held_r && !bvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign wr_fire = aw_held_r && w_held_r && !bvalid_r;
    assign wr_en = wr_fire && wlane_r && reg_hit(aw_idx_r);

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aw_held_r <= 1'b0;
            aw_idx_r <= 10'h000;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_held_r <= 1'b1;
            aw_idx_r <= s_axi_awaddr[11:2];
        end
        else if (wr_fire)
        begin
            aw_held_r <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            w_held_r <= 1'b0;
            wbyte_r <= 8'h00;
            wlane_r <= 1'b0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_held_r <= 1'b1;
            wbyte_r <= s_axi_wdata[7:0];
            wlane_r <= s_axi_wstrb[0];
        end
        else if (wr_fire)
        begin
            w_held_r <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bvalid_r <= 1'b0;
            bresp_r <= rtc_cal_pkg::RESP_OKAY;
        end
        else if (wr_fire)
        begin
            bvalid_r <= 1'b1;
            bresp_r <= reg_hit(aw_idx_r) ? rtc_cal_pkg::RESP_OKAY
                                         : rtc_cal_pkg::RESP_SLVERR;
        end
        else if (s_axi_bready)
        begin
            bvalid_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // calendar registers: a software write beats the tick
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hour_count_r <= rtc_cal_pkg::HOUR_RST;
        end
        else if (wr_en && aw_idx_r == rtc_cal_pkg::IDX_HOUR)
        begin
            hour_count_r <= wbyte_r[5:0];
        end
        else
        begin
            hour_count_r <= hour_nxt;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            weekday_count_r <= rtc_cal_pkg::WEEKDAY_RST;
        end
        else if (wr_en && aw_idx_r == rtc_cal_pkg::IDX_WEEKDAY)
        begin
            weekday_count_r <= wbyte_r[2:0];
        end
        else
        begin
            weekday_count_r <= weekday_nxt;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            month_day_count_r <= rtc_cal_pkg::MDAY_RST;
        end
        else if (wr_en && aw_idx_r == rtc_cal_pkg::IDX_MDAY)
        begin
            month_day_count_r <= wbyte_r[5:0];
        end
        else
        begin
            month_day_count_r <= mday_nxt;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            month_count_r <= rtc_cal_pkg::MONTH_RST;
        end
        else if (wr_en && aw_idx_r == rtc_cal_pkg::IDX_MONTH
                 && !bank_one_view_r)
        begin
            month_count_r <= wbyte_r[4:0];
        end
        else
        begin
            month_count_r <= month_nxt;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            clock_format_select_r <= rtc_cal_pkg::FMT_RST;
        end
        else if (wr_en && aw_idx_r == rtc_cal_pkg::IDX_MONTH
                 && bank_one_view_r)
        begin
            clock_format_select_r <= wbyte_r[rtc_cal_pkg::FMT_BIT];
        end
    end

    // plain store: a read-modify-write is not supported by design
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bank_one_view_r <= rtc_cal_pkg::PAGE_RST;
        end
        else if (wr_en && aw_idx_r == rtc_cal_pkg::IDX_PAGE)
        begin
            bank_one_view_r <= wbyte_r[rtc_cal_pkg::PAGE_BIT];
        end
    end

    // ------------------------------------------------------------
    // read channel
    // ------------------------------------------------------------
    assign ar_idx = s_axi_araddr[11:2];
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    always_comb
    begin
        rd_byte = 8'h00;
        unique case (ar_idx)
            rtc_cal_pkg::IDX_HOUR: rd_byte = {2'h0, hour_count_r};
            rtc_cal_pkg::IDX_WEEKDAY:
                rd_byte = {5'h00, weekday_count_r};
            rtc_cal_pkg::IDX_MDAY: rd_byte = {2'h0, month_day_count_r};
            rtc_cal_pkg::IDX_MONTH:
                rd_byte = bank_one_view_r ? {7'h00, clock_format_select_r}
                                          : {3'h0, month_count_r};
            rtc_cal_pkg::IDX_PAGE: rd_byte = {7'h00, bank_one_view_r};
            default: rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= rtc_cal_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_r <= 1'b1;
            rdata_r <= {24'h00_0000, rd_byte};
            rresp_r <= reg_hit(ar_idx) ? rtc_cal_pkg::RESP_OKAY
                                       : rtc_cal_pkg::RESP_SLVERR;
        end
        else if (s_axi_rready)
        begin
            rvalid_r <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ===== rtc_cal_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module rtc_cal_checker
(
    input wire logic ref_clk, // clock
    input wire logic rst_n, // reset, active low
    input wire logic hour_carry, // hour tick
    input wire logic year_carry, // year tick
    input wire logic s_axi_awvalid, // aw valid
    input wire logic s_axi_awready, // aw ready
    input wire logic s_axi_wvalid, // w valid
    input wire logic s_axi_wready, // w ready
    input wire logic [1:0] s_axi_bresp, // b response
    input wire logic s_axi_bvalid, // b valid
    input wire logic s_axi_bready, // b ready
    input wire logic s_axi_arvalid, // ar valid
    input wire logic s_axi_arready, // ar ready
    input wire logic [31:0] s_axi_rdata, // read data
    input wire logic [1:0] s_axi_rresp, // r response
    input wire logic s_axi_rvalid, // r valid
    input wire logic s_axi_rready // r ready
);
    // ------------------------------------------------------------
    // bus and counter relations
    // ------------------------------------------------------------
    default clocking dc @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    a_write_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> !s_axi_awready ##1 s_axi_bvalid)
        else $error("write answer not in two cycles");
    a_bresp_stands: assert property (
        s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer not next cycle");
    a_rdata_stands: assert property (
        s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read data dropped early");
    a_write_blocked: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    a_read_blocked: assert property (
        s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while data pending");
    a_upper_zero: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:6] == 26'h0)
        else $error("upper read bits not zero");
    a_error_zero: assert property (
        s_axi_rvalid && s_axi_rresp != rtc_cal_pkg::RESP_OKAY
        |-> s_axi_rresp == rtc_cal_pkg::RESP_SLVERR && s_axi_rdata == 0)
        else $error("bad error read");
    a_year_cause: assert property (
        year_carry |-> hour_carry)
        else $error("year carry without hour tick");
endmodule

bind rtc_calendar_time_registers rtc_cal_checker u_chk
(
    .ref_clk(ref_clk), .rst_n(rst_n), .hour_carry(hour_carry),
    .year_carry(year_carry), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);
`default_nettype wire

// ===== test_rtc_calendar_time_registers.sv
`timescale 1ns/1ns
`default_nettype none
module test_rtc_calendar_time_registers;
    localparam logic [11:0] A_HR = {rtc_cal_pkg::IDX_HOUR, 2'b00};
    localparam logic [11:0] A_WD = {rtc_cal_pkg::IDX_WEEKDAY, 2'b00};
    localparam logic [11:0] A_MD = {rtc_cal_pkg::IDX_MDAY, 2'b00};
    localparam logic [11:0] A_MO = {rtc_cal_pkg::IDX_MONTH, 2'b00};
    localparam logic [11:0] A_PG = {rtc_cal_pkg::IDX_PAGE, 2'b00};
    localparam logic [11:0] A_UN = 12'hc98;
    localparam logic [1:0] OK = rtc_cal_pkg::RESP_OKAY;
    localparam logic [1:0] ERR = rtc_cal_pkg::RESP_SLVERR;
    logic ref_clk = 1'b0, rst_n = 1'b0;
    logic hour_carry = 1'b0, leap_year = 1'b0, year_carry;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int err_count = 0, checks = 0;

    rtc_calendar_time_registers u_dut
    (
        .ref_clk(ref_clk), .rst_n(rst_n), .hour_carry(hour_carry),
        .leap_year(leap_year), .year_carry(year_carry),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready)
    );

    always #20 ref_clk = ~ref_clk;

    // ------------------------------------------------------------
    // compare, bus and tick tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d,
                      input logic [3:0] s, input logic [1:0] er);
        logic done;
        done = 1'b0;
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!done)
        begin
            @(posedge ref_clk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid)
            begin
                check({30'h0, s_axi_bresp}, {30'h0, er});
                s_axi_bready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask

    task automatic w(input logic [11:0] a, input logic [7:0] d);
        wr(a, d, 4'hf, OK);
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] e,
                      input logic [1:0] er);
        logic done;
        done = 1'b0;
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!done)
        begin
            @(posedge ref_clk);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid)
            begin
                check(s_axi_rdata, {24'h0, e});
                check({30'h0, s_axi_rresp}, {30'h0, er});
                s_axi_rready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask

    task automatic tick(input logic ey);
        @(posedge ref_clk);
        hour_carry <= 1'b1;
        @(negedge ref_clk);
        check({31'h0, year_carry}, {31'h0, ey});
        @(posedge ref_clk);
        hour_carry <= 1'b0;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_fields;
        logic [11:0] adr [4];
        logic [7:0] msk [4];
        adr = '{A_HR, A_WD, A_MD, A_MO};
        msk = '{8'h3f, 8'h07, 8'h3f, 8'h1f};
        rd(A_PG, 8'h00, OK);
        for (int i = 0; i < 4; i++)
        begin
            w(adr[i], 8'hff);
            rd(adr[i], msk[i], OK);
        end
        wr(A_HR, 8'h12, 4'h0, OK);
        rd(A_HR, 8'h3f, OK);
        $display("fields test done");
    endtask

    task automatic t_page;
        w(A_PG, 8'h01);
        rd(A_PG, 8'h01, OK);
        rd(A_MO, 8'h01, OK);
        w(A_MO, 8'hfe);
        rd(A_MO, 8'h00, OK);
        w(A_MO, 8'hff);
        rd(A_MO, 8'h01, OK);
        w(A_PG, 8'h00);
        rd(A_MO, 8'h1f, OK);
        rd(A_UN, 8'h00, ERR);
        wr(A_UN, 8'h55, 4'hf, ERR);
        $display("page test done");
    endtask

    task automatic t_count24;
        w(A_HR, 8'h09);
        tick(1'b0);
        rd(A_HR, 8'h10, OK);
        w(A_HR, 8'h19);
        tick(1'b0);
        rd(A_HR, 8'h20, OK);
        w(A_HR, 8'h23);
        w(A_WD, 8'h06);
        w(A_MD, 8'h31);
        w(A_MO, 8'h12);
        tick(1'b1);
        rd(A_HR, 8'h00, OK);
        rd(A_HR, 8'h00, OK);
        rd(A_WD, 8'h00, OK);
        rd(A_MD, 8'h01, OK);
        rd(A_MO, 8'h01, OK);
        w(A_MO, 8'h02);
        w(A_MD, 8'h28);
        w(A_HR, 8'h23);
        leap_year <= 1'b1;
        tick(1'b0);
        rd(A_MD, 8'h29, OK);
        w(A_MD, 8'h28);
        w(A_HR, 8'h23);
        leap_year <= 1'b0;
        tick(1'b0);
        rd(A_MD, 8'h01, OK);
        rd(A_MO, 8'h03, OK);
        $display("24 hour test done");
    endtask

    task automatic t_count12;
        w(A_PG, 8'h01);
        w(A_MO, 8'h00);
        w(A_PG, 8'h00);
        w(A_HR, 8'h11);
        w(A_MD, 8'h05);
        w(A_WD, 8'h02);
        tick(1'b0);
        rd(A_HR, 8'h20, OK);
        rd(A_MD, 8'h05, OK);
        w(A_HR, 8'h31);
        w(A_MD, 8'h30);
        w(A_MO, 8'h04);
        tick(1'b0);
        rd(A_HR, 8'h00, OK);
        rd(A_WD, 8'h03, OK);
        rd(A_MD, 8'h01, OK);
        rd(A_MO, 8'h05, OK);
        $display("12 hour test done");
    endtask

    // ------------------------------------------------------------
    // run control
    // ------------------------------------------------------------
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial
    begin
        repeat (5000) @(posedge ref_clk);
        err_count++;
        finish_test();
    end

    initial
    begin
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_fields();
        t_page();
        t_count24();
        t_count12();
        finish_test();
    end
endmodule
`default_nettype wire
